// *** include/adcsq_params.svh ***
/*
 * Constants of the ADC conversion sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes it is included by the package only, never compiled on its own.
 */
//
// Behaviour
// - Conversion clock is the instruction clock divided by four, fixed.
// - Inputs 0..3 form bank A, inputs 4..7 bank B, one sample-hold each.
// - Pipeline takes a sample each conversion tick; result emerges 4 ticks later.
// - Simultaneous mode samples pairs 0/4, 1/5, 2/6, 3/7 in that order.
// - Simultaneous pairs are sampled two conversion ticks apart, first right after start.
// - Sequential mode samples channels 0 to 7 one per conversion tick.
// - Each result is written left-aligned to its own channel result register.
// - A per-pair flag in the status register sets when that pair finishes.
// - When all eight results are written, the completion interrupt is raised.
// - After a sequence, channel 0 converts continuously into the monitor register.
// - Offset calibration ties both sample-hold terminals to the reference.
// - Gain calibration routes the calibration input to both sample-holds.
// - Per-channel range bits in range register; monitor range bit in status.
// - Control bit 0 selects start: clear is PWM sync edge, set is external pin edge.
// - Internal start runs a sequence on each PWM sync edge that arrives while no sequence is busy, once or twice per period.
// - Reset clears the start select bit, selecting PWM-synchronised start.
// - Control bits 4:3 select simultaneous, sequential, offset or gain mode; reset 00.
// - Result registers hold the 12-bit code in bits 15:4, low four bits zero.
// - Range register is eight bits, bit n for channel n.
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

`define ADCSQ_DIV_LAST 2'h3
`define ADCSQ_LAT 4
`define ADCSQ_FIFO_DEPTH 4

`define ADCSQ_OFF_RESULT0 4'h0
`define ADCSQ_OFF_RESULT7 4'h7
`define ADCSQ_OFF_MONITOR 4'h8
`define ADCSQ_OFF_RANGE 4'h9
`define ADCSQ_OFF_STATUS 4'ha
`define ADCSQ_OFF_CONTROL 4'hb

`define ADCSQ_CTL_SRC_BIT 0
`define ADCSQ_CTL_MODE_LSB 3
`define ADCSQ_CTL_MODE_MSB 4
`define ADCSQ_RST_SRC 1'h0
`define ADCSQ_RST_MODE 2'h0

`define ADCSQ_ST_MON_OTR_BIT 4
`define ADCSQ_ST_BUSY_BIT 5

`define ADCSQ_ALL_WRITTEN 8'hff
`define ADCSQ_LOW_ZERO 4'h0

`endif

// *** include/adcsq_pkg.sv ***
/*
 * Types shared by the ADC conversion sequencer files.
 * Assumes adcsq_params.svh is on the include path.
 */
`include "adcsq_params.svh"

package adcsq_pkg;

   typedef enum logic [1:0] {
      ADCSQ_MODE_SIMUL,
      ADCSQ_MODE_SEQ,
      ADCSQ_MODE_OFFSET,
      ADCSQ_MODE_GAIN
   } adcsq_mode_e;

   typedef enum logic [1:0] {
      ADCSQ_SRC_INPUT,
      ADCSQ_SRC_REFERENCE,
      ADCSQ_SRC_GAIN
   } adcsq_sha_src_e;

   typedef enum logic [1:0] {
      ADCSQ_IDLE,
      ADCSQ_SEQ,
      ADCSQ_MON
   } adcsq_state_e;

   typedef struct packed {
      logic valid;
      logic mon;
      logic [2:0] ch;
   } adcsq_tag_s;

   typedef struct packed {
      logic mon;
      logic [2:0] ch;
      logic out_of_range_bit;
      logic [11:0] code;
   } adcsq_word_s;

endpackage : adcsq_pkg

// *** src/adcsq_fifo.sv ***
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module adcsq_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Fill side.
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side.
   input wire logic i_out_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } adcsq_fifo_s;

   adcsq_fifo_s q;
   adcsq_fifo_s next_q;
   logic push;
   logic pop;

   assign o_in_ready = (q.count != (AW+1)'(DEPTH));
   assign o_out_valid = (q.count != '0);
   assign o_out_data = q.mem[q.rd];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb begin
      next_q = q;
      if (push) begin
         next_q.mem[q.wr] = i_in_data;
         next_q.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
      end
      if (pop) begin
         next_q.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
      end
      if (push && !pop) begin
         next_q.count = q.count + (AW+1)'(1);
      end else if (pop && !push) begin
         next_q.count = q.count - (AW+1)'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

endmodule : adcsq_fifo

// *** src/adcsq_sequencer.sv ***
/*
 * ADC conversion sequencer: start selection, sample-hold and multiplexer
 * sequencing, result and flag registers on the data memory port.
 * Assumes i_ref_clk is the instruction clock, the analogue core returns the
 * code of a sample on i_core_code/i_core_otr when its tag leaves the latency
 * line, and the register port is a simple synchronous data memory port.
 */
`timescale 1ns/1ps

module adcsq_sequencer (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Convert start sources.
   input wire logic i_pwm_period_sync,
   input wire logic i_ext_start_pin,
   // Data memory register port.
   input wire logic [3:0] i_dm_addr,
   input wire logic i_dm_rd,
   input wire logic i_dm_wr,
   input wire logic [15:0] i_dm_wdata,
   output logic [15:0] o_dm_rdata,
   // Analogue core control.
   output logic o_conv_tick,
   output logic o_sha_a_sample,
   output logic o_sha_b_sample,
   output logic [1:0] o_mux_a_sel,
   output logic [1:0] o_mux_b_sel,
   output logic o_core_from_b,
   output adcsq_pkg::adcsq_sha_src_e o_sha_src,
   // Analogue core result.
   input wire logic [11:0] i_core_code,
   input wire logic i_core_otr,
   // Completion interrupt.
   output logic o_conv_done_irq
);
   import adcsq_pkg::*;

   typedef struct packed {
      logic [1:0] div;
      logic tick;
      adcsq_state_e st;
      logic [2:0] step;
      logic start_src;
      adcsq_mode_e mode;
      logic prev_pwm;
      logic prev_ext;
      logic busy;
      adcsq_tag_s [`ADCSQ_LAT-1:0] tags;
      logic [7:0][15:0] result;
      logic [15:0] monitor;
      logic [7:0] range;
      logic [3:0] pair_done;
      logic mon_otr;
      logic [7:0] written;
      logic irq;
      logic [15:0] rdata;
      logic sha_a;
      logic sha_b;
      logic [1:0] mux_a;
      logic [1:0] mux_b;
      logic core_b;
      adcsq_sha_src_e src;
   } adcsq_seq_s;

   adcsq_seq_s q;
   adcsq_seq_s next_q;

   logic fifo_in_ready;
   logic fifo_in_valid;
   adcsq_word_s fifo_in;
   logic fifo_out_valid;
   logic fifo_out_ready;
   adcsq_word_s fifo_out;
   logic [16:0] fifo_out_raw;
   logic advance;
   logic start_edge;
   adcsq_tag_s tag_out;

   assign tag_out = q.tags[`ADCSQ_LAT-1];
   // The line only moves when the FIFO can take what leaves it.
   assign advance = q.tick & fifo_in_ready;
   assign fifo_in_valid = q.tick & tag_out.valid;
   assign fifo_in = '{mon: tag_out.mon, ch: tag_out.ch, out_of_range_bit: i_core_otr, code: i_core_code};
   // Register reads own the result store for their cycle.
   assign fifo_out_ready = ~i_dm_rd;
   assign fifo_out = adcsq_word_s'(fifo_out_raw);
   // Rising edge of the selected start source only.
   assign start_edge = q.start_src ? (i_ext_start_pin & ~q.prev_ext)
                                   : (i_pwm_period_sync & ~q.prev_pwm);

   adcsq_fifo #(
      .WIDTH($bits(adcsq_word_s)),
      .DEPTH(`ADCSQ_FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_in),
      .i_out_ready(fifo_out_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_raw)
   );

   always_comb begin
      adcsq_tag_s feed;
      logic [7:0] now_written;
      feed = '0;
      now_written = '0;
      next_q = q;
      next_q.irq = 1'b0;
      next_q.sha_a = 1'b0;
      next_q.sha_b = 1'b0;
      next_q.prev_pwm = i_pwm_period_sync;
      next_q.prev_ext = i_ext_start_pin;

      // Conversion tick from the free-running divider.
      next_q.div = q.div + 2'h1;
      next_q.tick = (q.div == `ADCSQ_DIV_LAST);

      // Sample-hold input routing follows the mode.
      case (q.mode)
         ADCSQ_MODE_OFFSET: next_q.src = ADCSQ_SRC_REFERENCE;
         ADCSQ_MODE_GAIN: next_q.src = ADCSQ_SRC_GAIN;
         default: next_q.src = ADCSQ_SRC_INPUT;
      endcase

      // Feeding the core, one sample per conversion tick.
      if (advance) begin
         case (q.st)
            ADCSQ_SEQ: begin
               feed.valid = 1'b1;
               if (q.mode == ADCSQ_MODE_SEQ) begin
                  feed.ch = q.step;
                  next_q.sha_a = ~q.step[2];
                  next_q.sha_b = q.step[2];
                  next_q.mux_a = q.step[1:0];
                  next_q.mux_b = q.step[1:0];
               end else begin
                  feed.ch = {q.step[0], q.step[2:1]};
                  next_q.sha_a = ~q.step[0];
                  next_q.sha_b = ~q.step[0];
                  next_q.mux_a = q.step[2:1];
                  next_q.mux_b = q.step[2:1];
               end
               next_q.core_b = feed.ch[2];
               next_q.step = q.step + 3'h1;
               if (q.step == 3'h7) begin
                  next_q.st = ADCSQ_MON;
               end
            end
            ADCSQ_MON: begin
               feed.valid = 1'b1;
               feed.mon = 1'b1;
               feed.ch = 3'h0;
               next_q.sha_a = 1'b1;
               next_q.mux_a = 2'h0;
               next_q.core_b = 1'b0;
            end
            default: begin
               feed = '0;
            end
         endcase
         // Latency line: a sample's code is taken as its tag leaves.
         next_q.tags = {q.tags[`ADCSQ_LAT-2:0], feed};
      end

      // Writing results drained from the FIFO.
      if (fifo_out_valid && fifo_out_ready) begin
         if (fifo_out.mon) begin
            next_q.monitor = {fifo_out.code, `ADCSQ_LOW_ZERO};
            next_q.mon_otr = fifo_out.out_of_range_bit;
         end else begin
            next_q.result[fifo_out.ch] = {fifo_out.code, `ADCSQ_LOW_ZERO};
            next_q.range[fifo_out.ch] = fifo_out.out_of_range_bit;
            now_written = q.written;
            now_written[fifo_out.ch] = 1'b1;
            next_q.written = now_written;
            if (fifo_out.ch[2] || q.mode == ADCSQ_MODE_SEQ) begin
               // A pair ends with its bank B member; in sequential mode the flag
               // only tracks channel order and must not be trusted.
               if (fifo_out.ch[2]) begin
                  next_q.pair_done[fifo_out.ch[1:0]] = 1'b1;
               end
            end
            if (now_written == `ADCSQ_ALL_WRITTEN) begin
               next_q.irq = 1'b1;
               next_q.busy = 1'b0;
               next_q.written = '0;
            end
         end
      end

      // A start is honoured only between sequences.
      if (start_edge && !q.busy) begin
         next_q.busy = 1'b1;
         next_q.st = ADCSQ_SEQ;
         next_q.step = 3'h0;
         next_q.pair_done = '0;
         next_q.written = '0;
      end

      // Register port, one-cycle read latency.
      next_q.rdata = '0;
      if (i_dm_rd) begin
         if (i_dm_addr <= `ADCSQ_OFF_RESULT7) begin
            next_q.rdata = q.result[i_dm_addr[2:0]];
         end else if (i_dm_addr == `ADCSQ_OFF_MONITOR) begin
            next_q.rdata = q.monitor;
         end else if (i_dm_addr == `ADCSQ_OFF_RANGE) begin
            next_q.rdata = {8'h00, q.range};
         end else if (i_dm_addr == `ADCSQ_OFF_STATUS) begin
            next_q.rdata[3:0] = q.pair_done;
            next_q.rdata[`ADCSQ_ST_MON_OTR_BIT] = q.mon_otr;
            next_q.rdata[`ADCSQ_ST_BUSY_BIT] = q.busy;
         end else if (i_dm_addr == `ADCSQ_OFF_CONTROL) begin
            next_q.rdata[`ADCSQ_CTL_SRC_BIT] = q.start_src;
            next_q.rdata[`ADCSQ_CTL_MODE_MSB:`ADCSQ_CTL_MODE_LSB] = q.mode;
         end else begin
            next_q.rdata = '0;
         end
      end
      if (i_dm_wr && i_dm_addr == `ADCSQ_OFF_CONTROL) begin
         next_q.start_src = i_dm_wdata[`ADCSQ_CTL_SRC_BIT];
         next_q.mode = adcsq_mode_e'(i_dm_wdata[`ADCSQ_CTL_MODE_MSB:`ADCSQ_CTL_MODE_LSB]);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
         q.st <= ADCSQ_IDLE;
         q.start_src <= `ADCSQ_RST_SRC;
         q.mode <= adcsq_mode_e'(`ADCSQ_RST_MODE);
         q.src <= ADCSQ_SRC_INPUT;
      end else begin
         q <= next_q;
      end
   end

   assign o_dm_rdata = q.rdata;
   assign o_conv_tick = q.tick;
   assign o_sha_a_sample = q.sha_a;
   assign o_sha_b_sample = q.sha_b;
   assign o_mux_a_sel = q.mux_a;
   assign o_mux_b_sel = q.mux_b;
   assign o_core_from_b = q.core_b;
   assign o_sha_src = q.src;
   assign o_conv_done_irq = q.irq;

endmodule : adcsq_sequencer

// *** tb/adc_conversion_sequencer_tb.sv ***
/* Self-checking bench of the conversion sequencer with a core model.
   Assumes the design files and package are compiled first. */
`timescale 1ns/1ps

module adc_conversion_sequencer_tb;
   import adcsq_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, sync = 1'b0, ext = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0, rdata, d;
   logic tick, sa, sb, from_b, out_of_range_bit, irq;
   logic [1:0] sel_a, sel_b;
   logic [11:0] code;
   adcsq_sha_src_e src;
   int checked = 0, fail_count = 0, c;

   always #5 clk = ~clk;

   adcsq_sequencer u_adcsq_sequencer (.i_ref_clk(clk), .i_arst_n(arst_n),
      .i_pwm_period_sync(sync), .i_ext_start_pin(ext), .i_dm_addr(addr), .i_dm_rd(rd),
      .i_dm_wr(wr), .i_dm_wdata(wdata), .o_dm_rdata(rdata), .o_conv_tick(tick),
      .o_sha_a_sample(sa), .o_sha_b_sample(sb), .o_mux_a_sel(sel_a), .o_mux_b_sel(sel_b),
      .o_core_from_b(from_b), .o_sha_src(src), .i_core_code(code), .i_core_otr(out_of_range_bit),
      .o_conv_done_irq(irq));
   adcsq_core_model u_adcsq_core_model (.i_ref_clk(clk), .i_arst_n(arst_n), .i_conv_tick(tick),
      .i_mux_a_sel(sel_a), .i_mux_b_sel(sel_b), .i_core_from_b(from_b), .i_sha_src(src),
      .o_code(code), .o_otr(out_of_range_bit));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic pulse(input logic use_ext);
      @(posedge clk);
      // A PWM period of whole ticks puts every sync edge on the conversion clock grid.
      while (!use_ext && tick !== 1'b1) @(posedge clk);
      if (use_ext) ext <= 1'b1;
      else sync <= 1'b1;
      repeat (2) @(posedge clk);
      ext <= 1'b0;
      sync <= 1'b0;
   endtask : pulse

   task automatic count_irq(input int n);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (irq === 1'b1) c++;
      end
   endtask : count_irq

   function automatic logic [15:0] exp_res(input logic [1:0] s, input logic [2:0] ch);
      return {1'b0, s, ch, 6'h2a, 4'h0};
   endfunction : exp_res

   task automatic check_bank(input logic [1:0] s);
      for (int ch = 0; ch < 8; ch++) begin
         rd_reg(ch[3:0]);
         chk("result", exp_res(s, ch[2:0]), d);
      end
   endtask : check_bank

   task automatic t_reset();
      rd_reg(4'hb);
      chk("control reset", 16'h0, d & 16'h0019);
      rd_reg(4'hc);
      chk("unmapped", 16'h0, d);
      wr_reg(4'hb, 16'h0019);
      rd_reg(4'hb);
      chk("control", 16'h0019, d & 16'h0019);
   endtask : t_reset

   task automatic t_simul();
      wr_reg(4'hb, 16'h0);
      pulse(1'b0);
      repeat (8) @(posedge clk);
      pulse(1'b0);
      pulse(1'b1);
      count_irq(300);
      chk("irq count", 16'h1, c[15:0]);
      check_bank(2'h0);
      rd_reg(4'h9);
      chk("range", 16'h0020, d);
      repeat (20) @(posedge clk);
      rd_reg(4'h8);
      chk("monitor", exp_res(2'h0, 3'h0), d);
      rd_reg(4'ha);
      chk("status", 16'h000f, d & 16'h003f);
   endtask : t_simul

   task automatic t_seq_ext();
      wr_reg(4'hb, 16'h0009);
      pulse(1'b0);
      count_irq(120);
      chk("no sync start", 16'h0, c[15:0]);
      pulse(1'b1);
      count_irq(300);
      chk("irq count", 16'h1, c[15:0]);
      check_bank(2'h0);
      rd_reg(4'h9);
      chk("range", 16'h0020, d);
   endtask : t_seq_ext

   task automatic t_calib();
      for (int m = 2; m < 4; m++) begin
         wr_reg(4'hb, {11'h0, m[1:0], 3'h1});
         pulse(1'b1);
         count_irq(300);
         chk("irq count", 16'h1, c[15:0]);
         check_bank(m == 2 ? 2'h1 : 2'h2);
      end
   endtask : t_calib

   task automatic summarize();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_simul();
      t_seq_ext();
      t_calib();
      summarize();
   end

   // The whole run needs under two thousand cycles.
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
endmodule : adc_conversion_sequencer_tb

// *** tb/adcsq_assertions.sv ***
/* Port checker of the conversion sequencer, bound into every instance.
   Assumes one instruction clock and an asynchronous active-low reset. */
`timescale 1ns/1ps

module adcsq_checker (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Start and register port.
   input wire logic i_pwm_period_sync,
   input wire logic i_ext_start_pin,
   input wire logic [3:0] i_dm_addr,
   input wire logic i_dm_rd,
   input wire logic i_dm_wr,
   input wire logic [15:0] i_dm_wdata,
   input wire logic [15:0] o_dm_rdata,
   // Core side.
   input wire logic o_conv_tick,
   input wire logic o_sha_a_sample,
   input wire logic o_sha_b_sample,
   input wire logic [1:0] o_mux_a_sel,
   input wire logic [1:0] o_mux_b_sel,
   input wire logic o_core_from_b,
   input wire adcsq_pkg::adcsq_sha_src_e o_sha_src,
   input wire logic [11:0] i_core_code,
   input wire logic i_core_otr,
   input wire logic o_conv_done_irq
);
   import adcsq_pkg::*;
   logic [2:0] ctl;

   // Shadow of the start select and mode bits as last written.
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctl <= 3'h0;
      end else if (i_dm_wr && i_dm_addr == 4'hb) begin
         ctl <= {i_dm_wdata[4:3], i_dm_wdata[0]};
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   a_tick_period: assert property (o_conv_tick |=> !o_conv_tick [*3] ##1 o_conv_tick)
      else $error("conversion tick spacing wrong");
   a_sample_a_tick: assert property (o_sha_a_sample |-> $past(o_conv_tick))
      else $error("bank A sample off the tick");
   a_sample_b_tick: assert property (o_sha_b_sample |-> $past(o_conv_tick))
      else $error("bank B sample off the tick");
   a_irq_single: assert property (o_conv_done_irq |=> !o_conv_done_irq [*3])
      else $error("completion pulse too long");
   a_rdata_idle: assert property (!$past(i_dm_rd) |-> o_dm_rdata == 16'h0)
      else $error("read data without read");
   a_unmapped_zero: assert property ($past(i_dm_rd) && $past(i_dm_addr) > 4'hb |-> o_dm_rdata == 16'h0)
      else $error("unmapped read not zero");
   a_result_low: assert property ($past(i_dm_rd) && $past(i_dm_addr) < 4'h9 |-> o_dm_rdata[3:0] == 4'h0)
      else $error("result low nibble not zero");
   a_range_width: assert property ($past(i_dm_rd) && $past(i_dm_addr) == 4'h9 |-> o_dm_rdata[15:8] == 8'h0)
      else $error("range register wider than eight bits");
   a_ctrl_read: assert property ($past(i_dm_rd) && $past(i_dm_addr) == 4'hb |-> {o_dm_rdata[4:3], o_dm_rdata[0]} == $past(ctl))
      else $error("control readback differs");
endmodule : adcsq_checker

bind adcsq_sequencer adcsq_checker u_adcsq_checker (.i_ref_clk, .i_arst_n, .i_pwm_period_sync,
   .i_ext_start_pin, .i_dm_addr, .i_dm_rd, .i_dm_wr, .i_dm_wdata, .o_dm_rdata, .o_conv_tick,
   .o_sha_a_sample, .o_sha_b_sample, .o_mux_a_sel, .o_mux_b_sel, .o_core_from_b, .o_sha_src,
   .i_core_code, .i_core_otr, .o_conv_done_irq);

// *** tb/adcsq_core_model.sv ***
/* Behavioural analogue core: returns a code naming the source and channel fed.
   Assumes feeds are registered one cycle after each conversion tick. */
`timescale 1ns/1ps

module adcsq_core_model (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Feed selection.
   input wire logic i_conv_tick,
   input wire logic [1:0] i_mux_a_sel,
   input wire logic [1:0] i_mux_b_sel,
   input wire logic i_core_from_b,
   input wire adcsq_pkg::adcsq_sha_src_e i_sha_src,
   // Result.
   output logic [11:0] o_code,
   output logic o_otr
);
   import adcsq_pkg::*;
   logic tick_d;
   logic [4:0] hist [4];

   // Four-deep history gives the pipeline latency in conversion ticks.
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick_d <= 1'b0;
         hist <= '{default: 5'h0};
      end else begin
         tick_d <= i_conv_tick;
         if (tick_d) begin
            hist[0] <= {i_sha_src, i_core_from_b, i_core_from_b ? i_mux_b_sel : i_mux_a_sel};
            hist[1:3] <= hist[0:2];
         end
      end
   end

   assign o_code = {1'b0, hist[3], 6'h2a};
   assign o_otr = hist[3][2:0] == 3'h5;
endmodule : adcsq_core_model
